//--- common/coef_addr_cfg.svh
// Constants of the coefficient and absolute address generator.
// Assumes a 25 MHz CPU clock and a decoder on the same clock.
//
// Contract
// - Coefficient addressing reuses pointer indirect generation
// - Offered to FIR, MPY, MAC, MAS, moves
// - Dual operands plus coefficient fetched one cycle
// - Dual multiply shares one coefficient operand
// - Double coefficient fetched as one 32-bit access
// - Single operand times low and high halves
// - Long operand words pair with coefficient halves
// - Qualifier 98 double coefficient only in dual access
// - 16-bit coefficient moves use data buses
// - 32-bit moves split words across buses
// - Coefficient read bus reaches internal memory only
// - Circular mode adds coefficient buffer start
// - Pointer arithmetic is 23 bits wide
// - Plain operand leaves pointer unchanged
// - Post-increment adds one or two
// - Post-decrement subtracts one or two
// - Bit access steps one, bit pair two
// - Indexed add uses temp or extended aux
// - Short absolute two bytes, long three
// - Absolute operand never issued in parallel
// - Short absolute is page high plus constant
// - Absolute supports single and long words
`ifndef COEF_ADDR_CFG_SVH
`define COEF_ADDR_CFG_SVH

`define ADDR_W 23
`define WORD_W 16
`define PAGE_HI_W 7
`define QUAL_SHARED 8'h98
`define SHORT_EXT_BYTES 3'h2
`define LONG_EXT_BYTES 3'h3
`define PTR_RESET 23'h000000
`define STEP_SINGLE 23'h000001
`define STEP_DOUBLE 23'h000002
`define INTERNAL_LIMIT 23'h010000
`define CLK_PERIOD_NS 40

`endif

//--- common/coef_addr_pkg.sv
// Types of the coefficient and absolute address generator.
// Assumes the constants header is compiled alongside.
package coef_addr_pkg;

    typedef enum logic [2:0] {
        OP_PLAIN = 3'b000,
        OP_POST_INC = 3'b001,
        OP_POST_DEC = 3'b010,
        OP_POST_INDEX = 3'b011,
        OP_ABS_SHORT = 3'b100,
        OP_ABS_LONG = 3'b101
    } operand_mode_t;

    typedef enum logic [1:0] {
        SZ_WORD = 2'b00,
        SZ_LONG = 2'b01,
        SZ_BIT = 2'b10,
        SZ_BIT_PAIR = 2'b11
    } access_size_t;

    typedef enum logic [1:0] {
        USE_OPERAND = 2'b00,
        USE_MOVE_READ = 2'b01,
        USE_MOVE_WRITE = 2'b10
    } coef_use_t;

endpackage

//--- src/coef_step_calc.sv
// Pointer step and circular address offset for coefficient addressing.
// Assumes purely combinational use by the main generator.
`timescale 1ns/100ps
`default_nettype none
`include "coef_addr_cfg.svh"

module coef_step_calc
    import coef_addr_pkg::*;
#(
    parameter int AW = `ADDR_W
) (
    // Operand
    input wire coef_addr_pkg::operand_mode_t mode_in,
    input wire coef_addr_pkg::access_size_t size_in,
    input wire logic [AW-1:0] pointer_in,
    input wire logic [`WORD_W-1:0] index_in,
    input wire logic circular_in,
    input wire logic [`WORD_W-1:0] buffer_start_in,
    // Results
    output logic [AW-1:0] address_out,
    output logic [AW-1:0] pointer_next_out
);
    import coef_addr_pkg::*;

    logic [AW-1:0] step;
    logic [AW-1:0] index_ext;

    // Double accesses and bit pairs step by two
    assign step = (size_in == SZ_LONG || size_in == SZ_BIT_PAIR) ?
        AW'(`STEP_DOUBLE) : AW'(`STEP_SINGLE);
    // Sign extension to full pointer width
    assign index_ext = {{(AW-`WORD_W){index_in[`WORD_W-1]}}, index_in};

    // Buffer start only in circular mode
    assign address_out = circular_in ?
        AW'(pointer_in + {{(AW-`WORD_W){1'b0}}, buffer_start_in}) :
        pointer_in;

    always_comb begin
        case (mode_in)
            OP_POST_INC: pointer_next_out = AW'(pointer_in + step);
            OP_POST_DEC: pointer_next_out = AW'(pointer_in - step);
            OP_POST_INDEX: pointer_next_out = AW'(pointer_in + index_ext);
            default: pointer_next_out = pointer_in;
        endcase
    end
endmodule // coef_step_calc

`default_nettype wire

//--- src/abs_addr_calc.sv
// Absolute address forming from instruction extension constants.
// Assumes the decoder has gathered the extension bytes already.
`timescale 1ns/100ps
`default_nettype none
`include "coef_addr_cfg.svh"

module abs_addr_calc
    import coef_addr_pkg::*;
#(
    parameter int AW = `ADDR_W
) (
    // Operand
    input wire logic long_form_in,
    input wire logic [`WORD_W-1:0] short_abs_constant_in,
    input wire logic [AW-1:0] long_abs_constant_in,
    input wire logic [`PAGE_HI_W-1:0] data_page_high_in,
    // Results
    output logic [AW-1:0] address_out,
    output logic [AW-1:0] address_second_out
);
    // Page high joined to the short constant
    assign address_out = long_form_in ? long_abs_constant_in :
        {data_page_high_in, short_abs_constant_in};
    // Second word of a long access sits one above
    assign address_second_out = AW'(address_out + AW'(1));
endmodule // abs_addr_calc

`default_nettype wire

//--- src/coef_absolute_address_gen.sv
// Coefficient pointer and absolute address generator of the DSP CPU.
// Assumes a decoder issuing one request pulse per instruction on clk_in.
//
`timescale 1ns/100ps
`default_nettype none
`include "coef_addr_cfg.svh"

module coef_absolute_address_gen
    import coef_addr_pkg::*;
#(
    parameter int AW = `ADDR_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Pointer load from the register file
    input wire logic pointer_load_in,
    input wire logic [AW-1:0] pointer_load_value_in,
    // Status and auxiliary state
    input wire logic circular_cfg_in,
    input wire logic legacy_compat_bit_in,
    input wire logic [`WORD_W-1:0] coef_buffer_start_in,
    input wire logic [`WORD_W-1:0] temp_reg_zero_in,
    input wire logic [AW-1:0] extended_aux_reg_zero_in,
    input wire logic [`PAGE_HI_W-1:0] data_page_high_in,
    // Decoder request
    input wire logic req_in,
    input wire coef_addr_pkg::operand_mode_t mode_in,
    input wire coef_addr_pkg::access_size_t size_in,
    input wire coef_addr_pkg::coef_use_t use_in,
    input wire logic dual_access_in,
    input wire logic [7:0] qualifier_in,
    input wire logic parallel_req_in,
    input wire logic [2:0] ext_bytes_in,
    input wire logic [`WORD_W-1:0] short_abs_constant_in,
    input wire logic [AW-1:0] long_abs_constant_in,
    // Coefficient read bus
    output logic coef_read_bus_req_out,
    output logic coef_read_bus_double_out,
    output logic [AW-1:0] coef_read_bus_addr_out,
    // Data buses
    output logic primary_read_bus_req_out,
    output logic [AW-1:0] primary_read_bus_addr_out,
    output logic second_read_bus_req_out,
    output logic [AW-1:0] second_read_bus_addr_out,
    output logic first_write_bus_req_out,
    output logic [AW-1:0] first_write_bus_addr_out,
    output logic second_write_bus_req_out,
    output logic [AW-1:0] second_write_bus_addr_out,
    // Decode and status
    output logic double_coef_operand_out,
    output logic mmap_qualifier_out,
    output logic reject_out,
    output logic external_coef_err_out,
    output logic [AW-1:0] extended_coef_pointer_out
);
    import coef_addr_pkg::*;

    // ------------------------------------------------------------
    // Address arithmetic
    // ------------------------------------------------------------
    logic [AW-1:0] extended_coef_pointer_reg;
    logic [AW-1:0] coef_addr;
    logic [AW-1:0] pointer_next;
    logic [AW-1:0] abs_addr;
    logic [AW-1:0] abs_addr_hi;
    logic [`WORD_W-1:0] index_value;
    logic is_abs;
    logic is_long;
    logic abs_bad;
    logic accept;
    logic coef_on_bus;
    logic qual_shared;

    // Index source picked by the compatibility bit
    assign index_value = legacy_compat_bit_in ?
        extended_aux_reg_zero_in[`WORD_W-1:0] : temp_reg_zero_in;

    // Same generator serves every pointer operand form
    coef_step_calc #(
        .AW(AW)
    ) u_step (
        .mode_in(mode_in),
        .size_in(size_in),
        .pointer_in(extended_coef_pointer_reg),
        .index_in(index_value),
        .circular_in(circular_cfg_in),
        .buffer_start_in(coef_buffer_start_in),
        .address_out(coef_addr),
        .pointer_next_out(pointer_next)
    );

    abs_addr_calc #(
        .AW(AW)
    ) u_abs (
        .long_form_in(mode_in == OP_ABS_LONG),
        .short_abs_constant_in(short_abs_constant_in),
        .long_abs_constant_in(long_abs_constant_in),
        .data_page_high_in(data_page_high_in),
        .address_out(abs_addr),
        .address_second_out(abs_addr_hi)
    );

    assign is_abs = (mode_in == OP_ABS_SHORT) || (mode_in == OP_ABS_LONG);
    assign is_long = (size_in == SZ_LONG);
    // Wrong extension length or a parallel issue is refused
    assign abs_bad = is_abs && (parallel_req_in ||
        (mode_in == OP_ABS_SHORT && ext_bytes_in != `SHORT_EXT_BYTES) ||
        (mode_in == OP_ABS_LONG && ext_bytes_in != `LONG_EXT_BYTES));
    assign accept = req_in && !abs_bad;
    assign coef_on_bus = accept && !is_abs && (use_in == USE_OPERAND);
    assign qual_shared = (qualifier_in == `QUAL_SHARED);

    // ------------------------------------------------------------
    // Pointer register
    // ------------------------------------------------------------
    // Update lands after the address is latched, so the next
    // instruction sees it; a load from software wins over stepping.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            extended_coef_pointer_reg <= `PTR_RESET;
        end else if (pointer_load_in) begin
            extended_coef_pointer_reg <= pointer_load_value_in;
        end else if (accept && !is_abs) begin
            extended_coef_pointer_reg <= pointer_next;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            extended_coef_pointer_out <= `PTR_RESET;
        end else if (pointer_load_in) begin
            extended_coef_pointer_out <= pointer_load_value_in;
        end else if (accept && !is_abs) begin
            extended_coef_pointer_out <= pointer_next;
        end
    end

    // ------------------------------------------------------------
    // Coefficient read bus
    // ------------------------------------------------------------
    // One access per cycle carries the coefficient beside the two
    // dual operands; a double operand takes both halves at once.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            coef_read_bus_req_out <= 1'b0;
            coef_read_bus_double_out <= 1'b0;
            coef_read_bus_addr_out <= '0;
        end else begin
            coef_read_bus_req_out <= coef_on_bus;
            coef_read_bus_double_out <= coef_on_bus && is_long;
            coef_read_bus_addr_out <= coef_on_bus ? coef_addr : '0;
        end
    end

    // Bus has no path off chip; flag a fetch outside internal memory
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            external_coef_err_out <= 1'b0;
        end else begin
            external_coef_err_out <= coef_on_bus &&
                (coef_addr >= AW'(`INTERNAL_LIMIT));
        end
    end

    // ------------------------------------------------------------
    // Qualifier decode
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            double_coef_operand_out <= 1'b0;
            mmap_qualifier_out <= 1'b0;
        end else begin
            double_coef_operand_out <= accept && qual_shared &&
                dual_access_in;
            mmap_qualifier_out <= accept && qual_shared &&
                !dual_access_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reject_out <= 1'b0;
        end else begin
            reject_out <= req_in && abs_bad;
        end
    end

    // ------------------------------------------------------------
    // Data read buses
    // ------------------------------------------------------------
    // Moves of coefficients avoid the coefficient bus; long reads put
    // the low word on the primary bus and the high word on the second.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            primary_read_bus_req_out <= 1'b0;
            primary_read_bus_addr_out <= '0;
            second_read_bus_req_out <= 1'b0;
            second_read_bus_addr_out <= '0;
        end else begin
            primary_read_bus_req_out <= 1'b0;
            primary_read_bus_addr_out <= '0;
            second_read_bus_req_out <= 1'b0;
            second_read_bus_addr_out <= '0;
            if (accept && is_abs) begin
                primary_read_bus_req_out <= 1'b1;
                primary_read_bus_addr_out <= abs_addr;
                second_read_bus_req_out <= is_long;
                second_read_bus_addr_out <= is_long ? abs_addr_hi : '0;
            end else if (accept && use_in == USE_MOVE_READ) begin
                primary_read_bus_req_out <= 1'b1;
                primary_read_bus_addr_out <= coef_addr;
                second_read_bus_req_out <= is_long;
                second_read_bus_addr_out <= is_long ?
                    AW'(coef_addr + AW'(1)) : '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Write buses
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            first_write_bus_req_out <= 1'b0;
            first_write_bus_addr_out <= '0;
            second_write_bus_req_out <= 1'b0;
            second_write_bus_addr_out <= '0;
        end else begin
            first_write_bus_req_out <= 1'b0;
            first_write_bus_addr_out <= '0;
            second_write_bus_req_out <= 1'b0;
            second_write_bus_addr_out <= '0;
            if (accept && !is_abs && use_in == USE_MOVE_WRITE) begin
                first_write_bus_req_out <= 1'b1;
                first_write_bus_addr_out <= coef_addr;
                second_write_bus_req_out <= is_long;
                second_write_bus_addr_out <= is_long ?
                    AW'(coef_addr + AW'(1)) : '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_post_inc_long;
        @(posedge clk_in) disable iff (!rst_b_in)
        (accept && !pointer_load_in && mode_in == OP_POST_INC &&
         size_in == SZ_LONG)
        |=> extended_coef_pointer_reg ==
            AW'($past(extended_coef_pointer_reg) + AW'(2));
    endproperty
    a_post_inc_long: assert property (p_post_inc_long)
        else $error("post increment long did not add two");

    property p_post_dec_word;
        @(posedge clk_in) disable iff (!rst_b_in)
        (accept && !pointer_load_in && mode_in == OP_POST_DEC &&
         size_in == SZ_WORD)
        |=> extended_coef_pointer_reg ==
            AW'($past(extended_coef_pointer_reg) - AW'(1));
    endproperty
    a_post_dec_word: assert property (p_post_dec_word)
        else $error("post decrement word did not subtract one");

    property p_plain_keeps;
        @(posedge clk_in) disable iff (!rst_b_in)
        (req_in && !pointer_load_in && mode_in == OP_PLAIN)
        |=> $stable(extended_coef_pointer_reg);
    endproperty
    a_plain_keeps: assert property (p_plain_keeps)
        else $error("plain operand changed the pointer");

    property p_linear_addr;
        @(posedge clk_in) disable iff (!rst_b_in)
        (coef_on_bus && !circular_cfg_in)
        |=> coef_read_bus_addr_out == $past(extended_coef_pointer_reg);
    endproperty
    a_linear_addr: assert property (p_linear_addr)
        else $error("linear coefficient address not the pointer");

    property p_parallel_abs;
        @(posedge clk_in) disable iff (!rst_b_in)
        (req_in && is_abs && parallel_req_in)
        |=> reject_out && !primary_read_bus_req_out;
    endproperty
    a_parallel_abs: assert property (p_parallel_abs)
        else $error("absolute operand issued in parallel");

    property p_move_no_coef_bus;
        @(posedge clk_in) disable iff (!rst_b_in)
        (req_in && use_in != USE_OPERAND)
        |=> !coef_read_bus_req_out;
    endproperty
    a_move_no_coef_bus: assert property (p_move_no_coef_bus)
        else $error("coefficient move used the coefficient bus");

    property p_short_abs;
        @(posedge clk_in) disable iff (!rst_b_in)
        (accept && mode_in == OP_ABS_SHORT)
        |=> primary_read_bus_addr_out ==
            {$past(data_page_high_in), $past(short_abs_constant_in)};
    endproperty
    a_short_abs: assert property (p_short_abs)
        else $error("short absolute address wrong");

    property p_long_pair;
        @(posedge clk_in) disable iff (!rst_b_in)
        (accept && use_in == USE_MOVE_WRITE && !is_abs && is_long)
        |=> second_write_bus_addr_out ==
            AW'(first_write_bus_addr_out + AW'(1));
    endproperty
    a_long_pair: assert property (p_long_pair)
        else $error("long write halves not adjacent");
endmodule // coef_absolute_address_gen

`default_nettype wire

//--- test/coef_mem_model.sv
// Memory-side model standing on the generator's coefficient read bus.
// Assumes bus requests are one-cycle pulses on the CPU clock.
`timescale 1ns/100ps
`default_nettype none
`include "coef_addr_cfg.svh"

module coef_mem_model (
    // Coefficient bus watched
    input wire logic coef_req_in,
    input wire logic [`ADDR_W-1:0] coef_addr_in,
    // Findings
    output logic external_hit_out
);
    // ------------------------------------------------------------
    // Internal memory window
    // ------------------------------------------------------------
    // The coefficient bus has no path to external memory, so any
    // request at or beyond the internal limit finds nothing here.
    assign external_hit_out = coef_req_in &&
        (coef_addr_in >= `INTERNAL_LIMIT);
endmodule // coef_mem_model
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the coefficient and absolute address generator.
// Assumes a fixed one-cycle answer to each decoder request pulse.
`timescale 1ns/100ps
`default_nettype none
`include "coef_addr_cfg.svh"

module tb;
    import coef_addr_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic pointer_load_in = 1'b0;
    logic [22:0] pointer_load_value_in = 23'h000000;
    logic circular_cfg_in = 1'b0;
    logic legacy_compat_bit_in = 1'b0;
    logic [15:0] coef_buffer_start_in = 16'h0000;
    logic [15:0] temp_reg_zero_in = 16'h0003;
    logic [22:0] extended_aux_reg_zero_in = 23'h000000;
    logic [6:0] data_page_high_in = 7'h00;
    logic req_in = 1'b0;
    operand_mode_t mode_in = OP_PLAIN;
    access_size_t size_in = SZ_WORD;
    coef_use_t use_in = USE_OPERAND;
    logic dual_access_in = 1'b0;
    logic [7:0] qualifier_in = 8'h00;
    logic parallel_req_in = 1'b0;
    logic [2:0] ext_bytes_in = 3'h0;
    logic [15:0] short_abs_constant_in = 16'h0000;
    logic [22:0] long_abs_constant_in = 23'h000000;
    logic coef_read_bus_req_out, coef_read_bus_double_out, reject_out;
    logic primary_read_bus_req_out, second_read_bus_req_out;
    logic first_write_bus_req_out, second_write_bus_req_out;
    logic double_coef_operand_out, mmap_qualifier_out, external_coef_err_out;
    logic [22:0] coef_read_bus_addr_out, primary_read_bus_addr_out;
    logic [22:0] second_read_bus_addr_out, first_write_bus_addr_out;
    logic [22:0] second_write_bus_addr_out, extended_coef_pointer_out;
    logic ext_hit;
    logic [22:0] ptr = 23'h000000;
    int n_fail = 0;
    int n_compared = 0;

    always #20 clk_in = ~clk_in;

    coef_absolute_address_gen #(.AW(23)) DUT (
        .clk_in, .rst_b_in, .pointer_load_in, .pointer_load_value_in,
        .circular_cfg_in, .legacy_compat_bit_in, .coef_buffer_start_in,
        .temp_reg_zero_in, .extended_aux_reg_zero_in, .data_page_high_in,
        .req_in, .mode_in, .size_in, .use_in, .dual_access_in, .qualifier_in,
        .parallel_req_in, .ext_bytes_in, .short_abs_constant_in,
        .long_abs_constant_in, .coef_read_bus_req_out,
        .coef_read_bus_double_out, .coef_read_bus_addr_out,
        .primary_read_bus_req_out, .primary_read_bus_addr_out,
        .second_read_bus_req_out, .second_read_bus_addr_out,
        .first_write_bus_req_out, .first_write_bus_addr_out,
        .second_write_bus_req_out, .second_write_bus_addr_out,
        .double_coef_operand_out, .mmap_qualifier_out, .reject_out,
        .external_coef_err_out, .extended_coef_pointer_out
    );

    coef_mem_model partner (
        .coef_req_in(coef_read_bus_req_out),
        .coef_addr_in(coef_read_bus_addr_out),
        .external_hit_out(ext_hit)
    );

    // ------------------------------------------------------------
    // Shared checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [22:0] got, input logic [22:0] exp,
                       input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic close_out();
        $display("Compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic load(input logic [22:0] v);
        @(posedge clk_in);
        pointer_load_in <= 1'b1;
        pointer_load_value_in <= v;
        @(posedge clk_in);
        pointer_load_in <= 1'b0;
        #1;
        chk(extended_coef_pointer_out, v, "pointer load");
        ptr = v;
    endtask

    // One request, then every output judged in its single answer cycle
    task automatic run(input operand_mode_t m, input access_size_t s,
                       input coef_use_t u);
        logic ab, rf, lg, cq, pq, wq;
        logic [15:0] ix;
        logic [22:0] a, nx, st;
        @(posedge clk_in);
        req_in <= 1'b1;
        mode_in <= m;
        size_in <= s;
        use_in <= u;
        ab = (m == OP_ABS_SHORT) || (m == OP_ABS_LONG);
        lg = (s == SZ_LONG);
        rf = ab && (parallel_req_in ||
             ext_bytes_in != ((m == OP_ABS_SHORT) ? 3'h2 : 3'h3));
        st = (lg || s == SZ_BIT_PAIR) ? 23'h000002 : 23'h000001;
        ix = legacy_compat_bit_in ? extended_aux_reg_zero_in[15:0]
                                  : temp_reg_zero_in;
        a = ptr + (circular_cfg_in ? {7'h00, coef_buffer_start_in} : 23'h0);
        if (m == OP_ABS_SHORT) a = {data_page_high_in, short_abs_constant_in};
        if (m == OP_ABS_LONG) a = long_abs_constant_in;
        nx = ptr;
        if (m == OP_POST_INC) nx = ptr + st;
        if (m == OP_POST_DEC) nx = ptr - st;
        if (m == OP_POST_INDEX) nx = ptr + {{7{ix[15]}}, ix};
        cq = !ab && u == USE_OPERAND;
        pq = ab ? !rf : (u == USE_MOVE_READ);
        wq = !ab && u == USE_MOVE_WRITE;
        @(posedge clk_in);
        req_in <= 1'b0;
        #1;
        chk(coef_read_bus_req_out, cq, "coef bus req");
        chk(coef_read_bus_double_out, cq && lg, "coef double");
        if (cq) chk(coef_read_bus_addr_out, a, "coef addr");
        chk(primary_read_bus_req_out, pq, "primary req");
        if (pq) chk(primary_read_bus_addr_out, a, "primary addr");
        chk(second_read_bus_req_out, pq && lg, "second req");
        if (pq && lg) chk(second_read_bus_addr_out, a + 1, "sec addr");
        chk(first_write_bus_req_out, wq, "first wr req");
        if (wq) chk(first_write_bus_addr_out, a, "first wr addr");
        chk(second_write_bus_req_out, wq && lg, "second wr req");
        if (wq && lg) chk(second_write_bus_addr_out, a + 1, "sw addr");
        chk(reject_out, rf, "reject");
        chk(external_coef_err_out, cq && a >= `INTERNAL_LIMIT, "ext");
        chk(ext_hit, cq && a >= `INTERNAL_LIMIT, "memory side");
        chk(double_coef_operand_out, qualifier_in == 8'h98 && dual_access_in,
            "double qualifier");
        chk(mmap_qualifier_out, qualifier_in == 8'h98 && !dual_access_in,
            "mmap qualifier");
        chk(extended_coef_pointer_out, nx, "pointer");
        ptr = nx;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_steps();
        load(23'h000100);
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 4; s++) begin
                run(operand_mode_t'(m[2:0]), access_size_t'(s[1:0]),
                    USE_OPERAND);
            end
        end
    endtask

    task automatic t_circular();
        circular_cfg_in <= 1'b1;
        coef_buffer_start_in <= 16'h0040;
        load(23'h000010);
        run(OP_POST_INC, SZ_WORD, USE_OPERAND);
        run(OP_POST_DEC, SZ_LONG, USE_MOVE_READ);
        circular_cfg_in <= 1'b0;
    endtask

    task automatic t_wide();
        load(23'h00FFFF);
        run(OP_POST_INC, SZ_LONG, USE_OPERAND);
        run(OP_PLAIN, SZ_WORD, USE_OPERAND);
    endtask

    task automatic t_index();
        temp_reg_zero_in <= 16'hFFFE;
        extended_aux_reg_zero_in <= 23'h7F0005;
        load(23'h000100);
        run(OP_POST_INDEX, SZ_WORD, USE_OPERAND);
        legacy_compat_bit_in <= 1'b1;
        run(OP_POST_INDEX, SZ_LONG, USE_OPERAND);
        legacy_compat_bit_in <= 1'b0;
    endtask

    task automatic t_moves();
        for (int s = 0; s < 2; s++) begin
            run(OP_POST_INC, access_size_t'(s[1:0]), USE_MOVE_READ);
            run(OP_POST_DEC, access_size_t'(s[1:0]), USE_MOVE_WRITE);
        end
    endtask

    task automatic t_abs();
        data_page_high_in <= 7'h03;
        short_abs_constant_in <= 16'h2002;
        long_abs_constant_in <= 23'h032002;
        ext_bytes_in <= 3'h2;
        run(OP_ABS_SHORT, SZ_WORD, USE_MOVE_READ);
        run(OP_ABS_SHORT, SZ_LONG, USE_MOVE_READ);
        run(OP_ABS_LONG, SZ_LONG, USE_MOVE_READ);
        ext_bytes_in <= 3'h3;
        run(OP_ABS_LONG, SZ_WORD, USE_MOVE_READ);
        parallel_req_in <= 1'b1;
        run(OP_ABS_LONG, SZ_LONG, USE_MOVE_READ);
        parallel_req_in <= 1'b0;
    endtask

    task automatic t_qualifier();
        qualifier_in <= 8'h98;
        dual_access_in <= 1'b1;
        run(OP_PLAIN, SZ_LONG, USE_OPERAND);
        dual_access_in <= 1'b0;
        run(OP_PLAIN, SZ_WORD, USE_MOVE_READ);
        qualifier_in <= 8'h97;
        run(OP_PLAIN, SZ_WORD, USE_OPERAND);
    endtask

    // Two requests on consecutive edges: the second sees the first's step
    task automatic t_back_to_back();
        load(23'h000020);
        @(posedge clk_in);
        req_in <= 1'b1;
        mode_in <= OP_POST_INC;
        size_in <= SZ_WORD;
        use_in <= USE_OPERAND;
        @(posedge clk_in);
        mode_in <= OP_POST_DEC;
        size_in <= SZ_LONG;
        #1;
        chk(coef_read_bus_addr_out, 23'h000020, "first addr");
        @(posedge clk_in);
        req_in <= 1'b0;
        #1;
        chk(coef_read_bus_addr_out, 23'h000021, "second addr");
        chk(extended_coef_pointer_out, 23'h00001F, "pointer");
        ptr = 23'h00001F;
    endtask

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        #1;
        chk(extended_coef_pointer_out, 23'h000000, "reset pointer");
        t_steps();
        t_circular();
        t_wide();
        t_index();
        t_moves();
        t_abs();
        t_qualifier();
        t_back_to_back();
        close_out();
    end

    initial begin
        repeat (5000) @(posedge clk_in);
        n_fail++;
        close_out();
    end
endmodule // tb
`default_nettype wire
